// >>> bench/sfb_decoder_model.sv
// Decoder-side model that issues register bus transfers to the flag block.
`timescale 1ns/10ps
module sfb_decoder_model (
  // Clock
  input  wire logic                           clk_i,
  // Bus requests out
  output logic                                psel_o,
  output logic                                penable_o,
  output logic                                pwrite_o,
  output logic [sfb_pkg::APB_ADDR_W-1:0]      paddr_o,
  output logic [sfb_pkg::APB_DATA_W-1:0]      pwdata_o,
  output logic [sfb_pkg::APB_STRB_W-1:0]      pstrb_o,
  // Answers in
  input  wire logic [sfb_pkg::APB_DATA_W-1:0] prdata_i,
  input  wire logic                           pready_i,
  input  wire logic                           pslverr_i
);
  initial begin
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwrite_o  <= 1'b0;
    paddr_o   <= 12'h000;
    pwdata_o  <= 32'h0;
    pstrb_o   <= 4'hf;
  end

  // One transfer: setup, then access held until pready is seen at an edge.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    rd = prdata_i;
    er = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o  <= ~d;
  endtask
endmodule

// >>> bench/status_flag_bit_ops_bench.sv
// Self-checking bench for the status flag and bit operation block.
`timescale 1ns/10ps
module status_flag_bit_ops_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  status, pre, ex;
  logic        er;
  int          n_mismatch = 0;
  int          compares   = 0;
  int          cycles     = 0;
  sfb_pkg::sfb_op_t fop [6];
  int          fpos [6];

  always #2 clk_i = ~clk_i;

  sfb_decoder_model dec (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  sfb_top uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .status_o(status));

  task automatic conclude;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    dec.xfer(1'b1, a, d, rd, er);
  endtask

  task automatic rdr(input logic [11:0] a);
    dec.xfer(1'b0, a, 32'h0, rd, er);
  endtask

  // Issues a command and looks at the status one step after its edge.
  task automatic cmd(input logic [3:0] op, input logic [4:0] r, input logic [2:0] b);
    wr(sfb_pkg::OFS_CMD, {13'h0, b, 3'h0, r, 4'h0, op});
    #1;
  endtask

  task automatic set_gpr(input logic [4:0] r, input logic [7:0] v);
    wr(sfb_pkg::OFS_GPR_SEL, {27'h0, r});
    wr(sfb_pkg::OFS_GPR_DATA, {24'h0, v});
  endtask

  task automatic load_check(input logic [7:0] st, input logic [7:0] init,
                            input logic [2:0] b, input logic [7:0] exp);
    wr(sfb_pkg::OFS_STATUS, {24'h0, st});
    set_gpr(5'h04, init);
    cmd(sfb_pkg::TRANSFER_TO_BIT_OP, 5'h04, b);
    cmp("status after load", {24'h0, st}, {24'h0, status});
    rdr(sfb_pkg::OFS_GPR_DATA);
    cmp("loaded register", {24'h0, exp}, rd);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    fop  = '{sfb_pkg::OVERFLOW_SET_OP, sfb_pkg::OVERFLOW_CLEAR_OP, sfb_pkg::SIGNED_SET_OP,
             sfb_pkg::SIGNED_CLEAR_OP, sfb_pkg::HALF_CARRY_SET_OP,
             sfb_pkg::HALF_CARRY_CLEAR_OP};
    fpos = '{sfb_pkg::FLAG_V, sfb_pkg::FLAG_V, sfb_pkg::FLAG_S, sfb_pkg::FLAG_S,
             sfb_pkg::FLAG_H, sfb_pkg::FLAG_H};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    cmp("status after reset", 32'h0, {24'h0, status});
    rdr(sfb_pkg::OFS_GPR_SEL);
    cmp("index after reset", 32'h0, rd);
    // Bit store: every bit position, other flags preloaded both ways.
    set_gpr(5'h03, 8'ha5);
    for (int b = 0; b < 8; b++) begin
      pre = (b % 2 == 0) ? 8'hbf : 8'h40;
      ex  = (pre & 8'hbf) | ({7'h0, ((8'ha5 >> b) & 8'h01) == 8'h01} << 6);
      wr(sfb_pkg::OFS_STATUS, {24'h0, pre});
      cmd(sfb_pkg::BIT_TO_TRANSFER_OP, 5'h03, b[2:0]);
      cmp("status after store", {24'h0, ex}, {24'h0, status});
    end
    load_check(8'h40, 8'h00, 3'h3, 8'h08);
    load_check(8'hbf, 8'hff, 3'h7, 8'h7f);
    // Flag set and clear codes, each against the opposite starting value.
    for (int i = 0; i < 6; i++) begin
      pre = (i % 2 == 0) ? 8'h00 : 8'hff;
      ex  = pre ^ (8'h01 << fpos[i]);
      wr(sfb_pkg::OFS_STATUS, {24'h0, pre});
      cmd(fop[i], 5'h00, 3'h0);
      cmp("status after flag op", {24'h0, ex}, {24'h0, status});
    end
    rdr(sfb_pkg::OFS_STATUS);
    cmp("status read", {24'h0, ex}, rd);
    // Refused code and unmapped address leave the state alone.
    wr(sfb_pkg::OFS_STATUS, 32'h55);
    cmd(4'h9, 5'h00, 3'h0);
    cmp("error on bad code", 32'h1, {31'h0, er});
    cmp("status after bad code", 32'h55, {24'h0, status});
    rdr(12'h010);
    cmp("error on unmapped", 32'h1, {31'h0, er});
    cmp("data on unmapped", 32'h0, rd);
    conclude();
  end
endmodule

// >>> rtl/sfb_bitop.sv
// Combinational bit and flag operation unit.
`timescale 1ns/10ps
module sfb_bitop (
  // Operation in, results out
  sfb_op_if.unit opif
);

  always_comb begin
    opif.status_out = opif.status_in;
    opif.gpr_wdata  = opif.gpr_rdata;
    opif.gpr_we     = 1'b0;
    opif.op_legal   = 1'b1;
    unique case (opif.op)
      sfb_pkg::NO_OP: begin
      end
      sfb_pkg::BIT_TO_TRANSFER_OP: begin
        opif.status_out[sfb_pkg::FLAG_T] = opif.gpr_rdata[opif.bit_sel];
      end
      sfb_pkg::TRANSFER_TO_BIT_OP: begin
        opif.gpr_wdata[opif.bit_sel] = opif.status_in[sfb_pkg::FLAG_T];
        opif.gpr_we                  = 1'b1;
      end
      sfb_pkg::OVERFLOW_SET_OP: begin
        opif.status_out[sfb_pkg::FLAG_V] = 1'b1;
      end
      sfb_pkg::OVERFLOW_CLEAR_OP: begin
        opif.status_out[sfb_pkg::FLAG_V] = 1'b0;
      end
      sfb_pkg::SIGNED_SET_OP: begin
        opif.status_out[sfb_pkg::FLAG_S] = 1'b1;
      end
      sfb_pkg::SIGNED_CLEAR_OP: begin
        opif.status_out[sfb_pkg::FLAG_S] = 1'b0;
      end
      sfb_pkg::HALF_CARRY_SET_OP: begin
        opif.status_out[sfb_pkg::FLAG_H] = 1'b1;
      end
      sfb_pkg::HALF_CARRY_CLEAR_OP: begin
        opif.status_out[sfb_pkg::FLAG_H] = 1'b0;
      end
      default: begin
        opif.op_legal = 1'b0;
      end
    endcase
  end

endmodule

// >>> rtl/sfb_op_if.sv
// Interface between the control logic and the bit operation unit.
`timescale 1ns/10ps
interface sfb_op_if;
  sfb_pkg::sfb_op_t                   op;
  logic [sfb_pkg::BIT_IDX_W-1:0]      bit_sel;
  logic [sfb_pkg::GPR_W-1:0]          gpr_rdata;
  logic [sfb_pkg::GPR_W-1:0]          status_in;
  logic [sfb_pkg::GPR_W-1:0]          status_out;
  logic [sfb_pkg::GPR_W-1:0]          gpr_wdata;
  logic                               gpr_we;
  logic                               op_legal;

  modport ctrl (
    output op, bit_sel, gpr_rdata, status_in,
    input  status_out, gpr_wdata, gpr_we, op_legal
  );
  modport unit (
    input  op, bit_sel, gpr_rdata, status_in,
    output status_out, gpr_wdata, gpr_we, op_legal
  );
endinterface

// >>> rtl/sfb_pkg.sv
// Constants and types shared by the status flag and bit operation block.
package sfb_pkg;

  // ---------------------------------------------------------------------------
  // Bus and data widths
  // ---------------------------------------------------------------------------
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned APB_STRB_W = 4;
  localparam int unsigned GPR_W      = 8;
  localparam int unsigned GPR_COUNT  = 32;
  localparam int unsigned GPR_IDX_W  = 5;
  localparam int unsigned BIT_IDX_W  = 3;
  localparam int unsigned OP_W       = 4;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [APB_ADDR_W-1:0] OFS_CMD      = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFS_STATUS   = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFS_GPR_SEL  = 12'h008;
  localparam logic [APB_ADDR_W-1:0] OFS_GPR_DATA = 12'h00c;

  // ---------------------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------------------
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_GPR_LSB = 8;
  localparam int unsigned CMD_BIT_LSB = 16;

  // ---------------------------------------------------------------------------
  // Status register flag positions
  // ---------------------------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [GPR_W-1:0]     STATUS_RST  = 8'h00;
  localparam logic [GPR_IDX_W-1:0] GPR_SEL_RST = 5'h00;

  // ---------------------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    NO_OP               = 4'h0,
    BIT_TO_TRANSFER_OP  = 4'h1,
    TRANSFER_TO_BIT_OP  = 4'h2,
    OVERFLOW_SET_OP     = 4'h3,
    OVERFLOW_CLEAR_OP   = 4'h4,
    SIGNED_SET_OP       = 4'h5,
    SIGNED_CLEAR_OP     = 4'h6,
    HALF_CARRY_SET_OP   = 4'h7,
    HALF_CARRY_CLEAR_OP = 4'h8
  } sfb_op_t;

endpackage

// >>> rtl/sfb_regfile.sv
// General register file with one write port and a registered read port.
`timescale 1ns/10ps
module sfb_regfile #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned DEPTH  = 32,
  parameter int unsigned IDX_W  = 5
) (
  // Clock
  input  wire logic              clk_i,
  // Write port
  input  wire logic              we_i,
  input  wire logic [IDX_W-1:0]  waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // Read port
  input  wire logic [IDX_W-1:0]  raddr_i,
  output logic      [DATA_W-1:0] rdata_o
);

  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end

endmodule

// >>> rtl/sfb_top.sv
// APB top level of the status flag and bit operation block.
`timescale 1ns/10ps

// What this block does
// - Bit-to-transfer op copies bit b of the source register into T, one cycle.
// - Transfer-to-bit op writes T into bit b of destination, flags unchanged.
// - Overflow set op forces V to one, clear op forces it zero.
// - Signed set op forces S to one, clear op forces it zero.
// - Half carry set op forces H to one, clear op forces it zero.
module sfb_top (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  // APB slave
  input  wire logic                             psel_i,
  input  wire logic                             penable_i,
  input  wire logic                             pwrite_i,
  input  wire logic [sfb_pkg::APB_ADDR_W-1:0]   paddr_i,
  input  wire logic [sfb_pkg::APB_DATA_W-1:0]   pwdata_i,
  input  wire logic [sfb_pkg::APB_STRB_W-1:0]   pstrb_i,
  output logic      [sfb_pkg::APB_DATA_W-1:0]   prdata_o,
  output logic                                  pready_o,
  output logic                                  pslverr_o,
  // Status register to the core
  output logic      [sfb_pkg::GPR_W-1:0]        status_o
);

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic                            pready_reg;
  logic                            pslverr_reg;
  logic [sfb_pkg::APB_DATA_W-1:0]  prdata_reg;
  logic [sfb_pkg::GPR_W-1:0]       status_reg;
  logic [sfb_pkg::GPR_IDX_W-1:0]   gpr_sel_reg;
  logic                            access;
  logic                            done;
  logic                            hit_cmd;
  logic                            hit_status;
  logic                            hit_sel;
  logic                            hit_data;
  logic                            unmapped;
  logic                            cmd_fire;
  logic                            status_wr;
  logic                            sel_wr;
  logic                            data_wr;
  logic                            mem_we;
  logic [sfb_pkg::GPR_IDX_W-1:0]   mem_waddr;
  logic [sfb_pkg::GPR_W-1:0]       mem_wdata;
  logic [sfb_pkg::GPR_IDX_W-1:0]   mem_raddr;
  logic [sfb_pkg::GPR_W-1:0]       mem_rdata;
  logic [sfb_pkg::GPR_IDX_W-1:0]   cmd_gpr;

  sfb_op_if opif ();

  assign access     = psel_i & penable_i;
  assign done       = access & pready_reg;
  assign hit_cmd    = (paddr_i == sfb_pkg::OFS_CMD);
  assign hit_status = (paddr_i == sfb_pkg::OFS_STATUS);
  assign hit_sel    = (paddr_i == sfb_pkg::OFS_GPR_SEL);
  assign hit_data   = (paddr_i == sfb_pkg::OFS_GPR_DATA);
  assign unmapped   = ~(hit_cmd | hit_status | hit_sel | hit_data);
  assign cmd_gpr    = pwdata_i[sfb_pkg::CMD_GPR_LSB +: sfb_pkg::GPR_IDX_W];

  // Commands run only at the completing edge of an error-free write.
  assign cmd_fire  = done & pwrite_i & hit_cmd & opif.op_legal;
  assign status_wr = done & pwrite_i & hit_status & pstrb_i[0];
  assign sel_wr    = done & pwrite_i & hit_sel & pstrb_i[0];
  assign data_wr   = done & pwrite_i & hit_data & pstrb_i[0];

  // ---------------------------------------------------------------------------
  // Operation unit and register file
  // ---------------------------------------------------------------------------
  // The register file is read from setup onward so its registered data is
  // ready before the access completes; this keeps each op to one edge.
  assign mem_raddr = hit_cmd ? cmd_gpr : gpr_sel_reg;
  assign mem_we    = (cmd_fire & opif.gpr_we) | data_wr;
  assign mem_waddr = hit_cmd ? cmd_gpr : gpr_sel_reg;
  assign mem_wdata = hit_cmd ? opif.gpr_wdata : pwdata_i[sfb_pkg::GPR_W-1:0];

  assign opif.op        = sfb_pkg::sfb_op_t'(pwdata_i[sfb_pkg::CMD_OP_LSB +: sfb_pkg::OP_W]);
  assign opif.bit_sel   = pwdata_i[sfb_pkg::CMD_BIT_LSB +: sfb_pkg::BIT_IDX_W];
  assign opif.gpr_rdata = mem_rdata;
  assign opif.status_in = status_reg;

  sfb_bitop u_bitop (
    .opif (opif.unit)
  );

  sfb_regfile #(
    .DATA_W (sfb_pkg::GPR_W),
    .DEPTH  (sfb_pkg::GPR_COUNT),
    .IDX_W  (sfb_pkg::GPR_IDX_W)
  ) u_regfile (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // ---------------------------------------------------------------------------
  // Status and select registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= sfb_pkg::STATUS_RST;
    end else if (status_wr) begin
      status_reg <= pwdata_i[sfb_pkg::GPR_W-1:0];
    end else if (cmd_fire) begin
      status_reg <= opif.status_out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpr_sel_reg <= sfb_pkg::GPR_SEL_RST;
    end else if (sel_wr) begin
      gpr_sel_reg <= pwdata_i[sfb_pkg::GPR_IDX_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------------
  // Every transfer has exactly one wait cycle in its access phase.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access & ~pready_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= access & ~pready_reg & (unmapped | (hit_cmd & pwrite_i & ~opif.op_legal));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_reg <= '0;
    end else if (access & ~pready_reg & ~pwrite_i) begin
      if (hit_status) begin
        prdata_reg <= {24'h000000, status_reg};
      end else if (hit_sel) begin
        prdata_reg <= {27'h0000000, gpr_sel_reg};
      end else if (hit_data) begin
        prdata_reg <= {24'h000000, mem_rdata};
      end else begin
        prdata_reg <= '0;
      end
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign status_o  = status_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_store_copies_bit: assert property (
    cmd_fire && opif.op == sfb_pkg::BIT_TO_TRANSFER_OP
    |=> status_reg[sfb_pkg::FLAG_T] == $past(mem_rdata[opif.bit_sel]))
    else $error("transfer flag not loaded from register bit");

  a_store_only_t: assert property (
    cmd_fire && opif.op == sfb_pkg::BIT_TO_TRANSFER_OP
    |=> (status_reg & 8'hbf) == ($past(status_reg) & 8'hbf))
    else $error("bit store changed a flag other than T");

  a_load_writes_bit: assert property (
    cmd_fire && opif.op == sfb_pkg::TRANSFER_TO_BIT_OP
    |-> mem_we && mem_waddr == cmd_gpr
        && mem_wdata[opif.bit_sel] == status_reg[sfb_pkg::FLAG_T]
        && (mem_wdata ^ mem_rdata)
           == (8'h01 << opif.bit_sel) * (mem_wdata[opif.bit_sel] ^ mem_rdata[opif.bit_sel]))
    else $error("bit load wrote wrong register value");

  a_load_flags_kept: assert property (
    cmd_fire && opif.op == sfb_pkg::TRANSFER_TO_BIT_OP |=> $stable(status_reg))
    else $error("bit load changed the status register");

  a_v_set_clear: assert property (
    cmd_fire && (opif.op == sfb_pkg::OVERFLOW_SET_OP || opif.op == sfb_pkg::OVERFLOW_CLEAR_OP)
    |=> status_reg[sfb_pkg::FLAG_V] == $past(opif.op == sfb_pkg::OVERFLOW_SET_OP)
        && (status_reg & 8'hf7) == ($past(status_reg) & 8'hf7))
    else $error("overflow flag op wrong");

  a_s_set_clear: assert property (
    cmd_fire && (opif.op == sfb_pkg::SIGNED_SET_OP || opif.op == sfb_pkg::SIGNED_CLEAR_OP)
    |=> status_reg[sfb_pkg::FLAG_S] == $past(opif.op == sfb_pkg::SIGNED_SET_OP)
        && (status_reg & 8'hef) == ($past(status_reg) & 8'hef))
    else $error("signed flag op wrong");

  a_h_set_clear: assert property (
    cmd_fire && (opif.op == sfb_pkg::HALF_CARRY_SET_OP || opif.op == sfb_pkg::HALF_CARRY_CLEAR_OP)
    |=> status_reg[sfb_pkg::FLAG_H] == $past(opif.op == sfb_pkg::HALF_CARRY_SET_OP)
        && (status_reg & 8'hdf) == ($past(status_reg) & 8'hdf))
    else $error("half carry flag op wrong");

  a_flags_idle: assert property (
    !cmd_fire && !status_wr |=> $stable(status_reg))
    else $error("status changed without a command");

  a_one_wait: assert property (
    access && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("answer not after one wait cycle");

  a_store_no_write: assert property (
    cmd_fire && opif.op == sfb_pkg::BIT_TO_TRANSFER_OP |-> !mem_we)
    else $error("bit store wrote the register file");

  a_flag_no_write: assert property (
    cmd_fire && opif.op >= sfb_pkg::OVERFLOW_SET_OP && opif.op <= sfb_pkg::HALF_CARRY_CLEAR_OP
    |-> !mem_we)
    else $error("flag op wrote the register file");

  a_status_write: assert property (
    status_wr |=> status_reg == $past(pwdata_i[sfb_pkg::GPR_W-1:0]))
    else $error("status register write lost");

  a_sel_write: assert property (
    sel_wr |=> gpr_sel_reg == $past(pwdata_i[sfb_pkg::GPR_IDX_W-1:0]))
    else $error("register index write lost");

  a_sel_idle: assert property (
    !sel_wr |=> $stable(gpr_sel_reg))
    else $error("register index changed without a write");

  a_data_write: assert property (
    data_wr |-> mem_we && mem_waddr == gpr_sel_reg
                && mem_wdata == pwdata_i[sfb_pkg::GPR_W-1:0])
    else $error("register data write misrouted");

  a_err_with_ready: assert property (
    pslverr_reg |-> pready_reg)
    else $error("error flag without an answer");

  a_unmapped_err: assert property (
    access && !pready_reg && unmapped |=> pslverr_reg)
    else $error("unmapped access not refused");

  a_no_err_mapped: assert property (
    access && !pready_reg && !unmapped && !(hit_cmd && pwrite_i && !opif.op_legal)
    |=> !pslverr_reg)
    else $error("error raised on a legal access");

  a_bad_op_err: assert property (
    access && !pready_reg && pwrite_i && hit_cmd && !opif.op_legal |=> pslverr_reg)
    else $error("illegal command not refused");

  a_bad_op_kept: assert property (
    done && pwrite_i && hit_cmd && !opif.op_legal |-> !mem_we ##1 $stable(status_reg))
    else $error("illegal command changed state");

  a_op_decode: assert property (
    opif.op_legal
    == (pwdata_i[sfb_pkg::CMD_OP_LSB +: sfb_pkg::OP_W] <= sfb_pkg::HALF_CARRY_CLEAR_OP))
    else $error("command code legality decoded wrong");

  a_read_status: assert property (
    access && !pready_reg && !pwrite_i && hit_status
    |=> prdata_reg == {24'h000000, $past(status_reg)})
    else $error("status read returned wrong data");

  a_read_sel: assert property (
    access && !pready_reg && !pwrite_i && hit_sel
    |=> prdata_reg == {27'h0000000, $past(gpr_sel_reg)})
    else $error("index read returned wrong data");

  a_read_unmapped: assert property (
    access && !pready_reg && !pwrite_i && unmapped |=> prdata_reg == '0)
    else $error("unmapped read returned data");

  a_cmd_read_zero: assert property (
    access && !pready_reg && !pwrite_i && hit_cmd |=> prdata_reg == '0)
    else $error("command read returned data");

  a_ready_after_access: assert property (
    pready_reg |-> $past(access) && !$past(pready_reg))
    else $error("answer without a pending access");

  a_reset_values: assert property (disable iff (1'b0)
    rst_i |=> !pready_reg && !pslverr_reg && prdata_reg == '0
              && status_reg == sfb_pkg::STATUS_RST && gpr_sel_reg == sfb_pkg::GPR_SEL_RST)
    else $error("reset values not taken");

  // ---------------------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------------------
  c_store: cover property (cmd_fire && opif.op == sfb_pkg::BIT_TO_TRANSFER_OP);
  c_load: cover property (cmd_fire && opif.op == sfb_pkg::TRANSFER_TO_BIT_OP);
  c_store_then_load: cover property (
    cmd_fire && opif.op == sfb_pkg::BIT_TO_TRANSFER_OP
    ##[1:10] cmd_fire && opif.op == sfb_pkg::TRANSFER_TO_BIT_OP);
  c_err: cover property (pslverr_reg && pready_reg);
  c_flag_op: cover property (cmd_fire && opif.op == sfb_pkg::HALF_CARRY_CLEAR_OP);

endmodule
